// >>> include/mbsfe_pkg.sv
`default_nettype none
package mbsfe_pkg;
  // supported function codes
  localparam logic [7:0] FC_READ_HOLD = 8'h03;
  localparam logic [7:0] FC_READ_INPUT = 8'h04;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_DIAG = 8'h08;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] FC_READ_WRITE = 8'h17;
  localparam logic [7:0] FC_EXC_FLAG = 8'h80;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [15:0] DIAG_SUB_LOOPBACK = 16'h0000;
  localparam logic [15:0] DIAG_SUB_REGISTER = 16'h0002;
  // register count limits
  localparam logic [15:0] MAX_READ_REGS = 16'h007D;
  localparam logic [15:0] MAX_WRITE_REGS = 16'h0078;
  localparam logic [15:0] MAX_RW_REGS = 16'h0076;
  // byte order selections
  localparam logic [1:0] BO_1032 = 2'h0;
  localparam logic [1:0] BO_0123 = 2'h1;
  localparam logic [1:0] BO_2301 = 2'h2;
  localparam logic [1:0] BO_3210 = 2'h3;
  localparam logic [1:0] BO_RESET = BO_1032;
  // value types of the register area
  localparam logic [1:0] TYPE_INT = 2'h0;
  localparam logic [1:0] TYPE_FLOAT = 2'h1;
  localparam logic [1:0] TYPE_STRING = 2'h2;
  // response timing
  localparam int CLK_FREQ_KHZ = 200000;
  localparam int RESP_MIN_US = 3000;
  localparam int RESP_MIN_CYC = (RESP_MIN_US * CLK_FREQ_KHZ + 999) / 1000;
  localparam logic [2:0] HDR_BYTES_MAX = 3'h5;

  typedef struct packed {
    logic broadcast;
    logic [7:0] func;
    logic [15:0] sub_func;
    logic [15:0] addr;
    logic [15:0] count;
    logic [15:0] wr_addr;
    logic [15:0] wr_count;
    logic [15:0] value;
  } mbsfe_req_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } mbsfe_reg_cmd_t;

  typedef struct packed {
    logic ack;
    logic [1:0] rtype;
    logic [31:0] rdata;
  } mbsfe_reg_rsp_t;
endpackage : mbsfe_pkg
`default_nettype wire

// >>> verilog/mbsfe_byte_order.sv
`timescale 1ns/10ps
`default_nettype none
module mbsfe_byte_order (
  input wire logic [1:0] order_i,
  input wire logic [1:0] rtype_i,
  input wire logic [31:0] value_i,
  output logic [31:0] seq_o,
  output logic four_o
);
  import mbsfe_pkg::*;

  wire [7:0] b3 = value_i[31:24];
  wire [7:0] b2 = value_i[23:16];
  wire [7:0] b1 = value_i[15:8];
  wire [7:0] b0 = value_i[7:0];
  wire is_float = (rtype_i == TYPE_FLOAT);
  wire msb_first = (order_i == BO_1032) || (order_i == BO_3210);
  wire [31:0] float_seq = (order_i == BO_1032) ? {b1, b0, b3, b2} :
                          (order_i == BO_0123) ? {b0, b1, b2, b3} :
                          (order_i == BO_2301) ? {b2, b3, b0, b1} : {b3, b2, b1, b0};
  wire [31:0] word_seq = msb_first ? {b1, b0, 16'h0000} : {b0, b1, 16'h0000};

  assign seq_o = is_float ? float_seq : word_seq;
  assign four_o = is_float;
endmodule : mbsfe_byte_order
`default_nettype wire

// >>> verilog/mbsfe_engine.sv
`timescale 1ns/10ps
`default_nettype none
module mbsfe_engine #(
  parameter int RESP_DELAY_CYC = mbsfe_pkg::RESP_MIN_CYC
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic CE_I,
  input wire logic REQ_VALID_I,
  input wire mbsfe_pkg::mbsfe_req_t REQ_I,
  output logic REQ_READY_O,
  input wire logic WORD_VALID_I,
  input wire logic [15:0] WORD_I,
  output logic WORD_READY_O,
  output mbsfe_pkg::mbsfe_reg_cmd_t REG_CMD_O,
  input wire mbsfe_pkg::mbsfe_reg_rsp_t REG_RSP_I,
  input wire logic [15:0] DIAG_REG_I,
  input wire logic BYTE_ORDER_LOAD_I,
  input wire logic [1:0] BYTE_ORDER_I,
  input wire logic MAINS_PRESENT_I,
  input wire logic POWER_SAVE_ENABLE_SWITCH_I,
  output logic XCVR_ON_O,
  output logic RSP_VALID_O,
  output logic [7:0] RSP_BYTE_O,
  output logic RSP_LAST_O,
  input wire logic RSP_READY_I
);
  import mbsfe_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_DECODE, S_WR_GET, S_WR_WAIT, S_HDR, S_RD_REQ, S_RD_WAIT, S_DATA, S_END
  } mbsfe_state_t;

  mbsfe_state_t state_reg;
  mbsfe_req_t req_reg;
  mbsfe_reg_cmd_t cmd_reg;
  logic exc_reg;
  logic [7:0] exc_code_reg;
  logic awake_reg;
  logic xcvr_reg;
  logic [1:0] byte_order_reg;
  logic [23:0] delay_cnt_reg;
  logic [15:0] wr_left_reg;
  logic [15:0] wr_addr_reg;
  logic [15:0] rd_left_reg;
  logic [15:0] rd_addr_reg;
  logic [2:0] idx_reg;
  logic [31:0] dbuf_reg;
  logic [2:0] dlen_reg;
  logic rsp_valid_reg;
  logic [7:0] rsp_byte_reg;
  logic rsp_last_reg;
  logic req_ready_reg;
  logic word_ready_reg;

  // function decode
  // codes 03 and 04 share one path
  wire fc_rd = (req_reg.func == FC_READ_HOLD) || (req_reg.func == FC_READ_INPUT);
  wire fc_w1 = (req_reg.func == FC_WRITE_SINGLE);
  wire fc_diag = (req_reg.func == FC_DIAG);
  wire fc_wm = (req_reg.func == FC_WRITE_MULTI);
  wire fc_rw = (req_reg.func == FC_READ_WRITE);
  wire diag_loop = (req_reg.sub_func == DIAG_SUB_LOOPBACK);
  wire diag_reg = (req_reg.sub_func == DIAG_SUB_REGISTER);
  wire fc_illegal = !(fc_rd || fc_w1 || fc_wm || fc_rw || (fc_diag && (diag_loop || diag_reg)));
  wire bc_allowed = fc_w1 || fc_wm || fc_rw;
  wire rd_bad = (req_reg.count == 16'h0000) || (req_reg.count > MAX_READ_REGS);
  wire wm_bad = (req_reg.wr_count == 16'h0000) || (req_reg.wr_count > MAX_WRITE_REGS);
  wire rw_bad = (req_reg.count == 16'h0000) || (req_reg.count > MAX_RW_REGS) ||
                (req_reg.wr_count == 16'h0000) || (req_reg.wr_count > MAX_RW_REGS);
  wire count_bad = (fc_rd && rd_bad) || (fc_wm && wm_bad) || (fc_rw && rw_bad);

  // power save status
  wire ps_active = POWER_SAVE_ENABLE_SWITCH_I && !MAINS_PRESENT_I;
  wire comm_blocked = !POWER_SAVE_ENABLE_SWITCH_I && !MAINS_PRESENT_I;

  // incoming words unpacked with the selected integer order
  wire lsb_first = (byte_order_reg == BO_0123) || (byte_order_reg == BO_2301);
  wire [15:0] word_in = lsb_first ? {WORD_I[7:0], WORD_I[15:8]} : WORD_I;
  wire [15:0] value_in = lsb_first ? {req_reg.value[7:0], req_reg.value[15:8]} : req_reg.value;

  // response header
  wire has_data = (fc_rd || fc_rw) && !exc_reg;
  wire [7:0] byte_cnt = {req_reg.count[6:0], 1'b0};
  wire [2:0] hdr_len = (exc_reg || has_data) ? 3'h2 : HDR_BYTES_MAX;
  wire [15:0] echo_hi = fc_w1 ? req_reg.addr : fc_wm ? req_reg.wr_addr : req_reg.sub_func;
  wire [15:0] echo_lo = fc_w1 ? req_reg.value : fc_wm ? req_reg.wr_count :
                        diag_reg ? DIAG_REG_I : req_reg.value;
  wire [7:0] hdr0 = exc_reg ? (req_reg.func | FC_EXC_FLAG) : req_reg.func;
  wire [7:0] hdr1 = exc_reg ? exc_code_reg : has_data ? byte_cnt : echo_hi[15:8];
  wire [7:0] hdr_byte = (idx_reg == 3'h0) ? hdr0 :
                        (idx_reg == 3'h1) ? hdr1 :
                        (idx_reg == 3'h2) ? echo_hi[7:0] :
                        (idx_reg == 3'h3) ? echo_lo[15:8] : echo_lo[7:0];
  wire [7:0] cur_byte = (state_reg == S_DATA) ? dbuf_reg[31:24] : hdr_byte;

  wire delay_done = (delay_cnt_reg >= 24'(RESP_DELAY_CYC));
  wire take = rsp_valid_reg && RSP_READY_I;
  wire [15:0] dwords = (dlen_reg == 3'h4) ? 16'h0002 : 16'h0001;
  wire hdr_last = (idx_reg == hdr_len - 3'h1);
  wire data_last = (idx_reg == dlen_reg - 3'h1);
  wire end_last = (state_reg == S_DATA) ? (data_last && (rd_left_reg == dwords)) : (hdr_last && !has_data);
  wire sending = ((state_reg == S_HDR) && delay_done) || (state_reg == S_DATA);

  // value formatting
  wire [31:0] fmt_seq;
  wire fmt_four;
  mbsfe_byte_order u_order (
    .order_i(byte_order_reg),
    .rtype_i(REG_RSP_I.rtype),
    .value_i(REG_RSP_I.rdata),
    .seq_o(fmt_seq),
    .four_o(fmt_four)
  );
  wire load_four = fmt_four && (rd_left_reg >= 16'h0002);

  // byte order setting
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      byte_order_reg <= BO_RESET;
    end else if (CE_I && BYTE_ORDER_LOAD_I) begin
      byte_order_reg <= BYTE_ORDER_I;
    end
  end

  // turnaround counter
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      delay_cnt_reg <= 24'h000000;
    end else if (CE_I) begin
      if (state_reg == S_DECODE) begin
        delay_cnt_reg <= 24'h000000;
      end else if (!delay_done) begin
        delay_cnt_reg <= delay_cnt_reg + 24'h000001;
      end
    end
  end

  // transceiver supply
  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      xcvr_reg <= 1'b0;
    end else if (CE_I) begin
      xcvr_reg <= MAINS_PRESENT_I || (POWER_SAVE_ENABLE_SWITCH_I && awake_reg);
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (!RESETN_I) begin
      state_reg <= S_IDLE;
      req_reg <= '0;
      cmd_reg <= '0;
      exc_reg <= 1'b0;
      exc_code_reg <= 8'h00;
      awake_reg <= 1'b0;
      wr_left_reg <= 16'h0000;
      wr_addr_reg <= 16'h0000;
      rd_left_reg <= 16'h0000;
      rd_addr_reg <= 16'h0000;
      idx_reg <= 3'h0;
      dbuf_reg <= 32'h00000000;
      dlen_reg <= 3'h2;
      rsp_valid_reg <= 1'b0;
      rsp_byte_reg <= 8'h00;
      rsp_last_reg <= 1'b0;
      req_ready_reg <= 1'b0;
      word_ready_reg <= 1'b0;
    end else if (CE_I) begin
      req_ready_reg <= 1'b0;
      cmd_reg.rd <= 1'b0;
      cmd_reg.wr <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          if (REQ_VALID_I && req_ready_reg) begin
            req_reg <= REQ_I;
            state_reg <= S_DECODE;
          end else begin
            req_ready_reg <= 1'b1;
          end
        end
        S_DECODE: begin
          exc_reg <= fc_illegal || count_bad;
          exc_code_reg <= fc_illegal ? EXC_ILLEGAL_FUNC : EXC_ILLEGAL_VALUE;
          rd_addr_reg <= req_reg.addr;
          rd_left_reg <= req_reg.count;
          wr_addr_reg <= req_reg.wr_addr;
          wr_left_reg <= req_reg.wr_count;
          idx_reg <= 3'h0;
          if (comm_blocked) begin
            state_reg <= S_IDLE;
          end else if (ps_active && !awake_reg) begin
            awake_reg <= 1'b1;
            state_reg <= S_IDLE;
          end else if (req_reg.broadcast && (!bc_allowed || count_bad)) begin
            state_reg <= S_END;
          end else if (fc_illegal || count_bad) begin
            state_reg <= S_HDR;
          end else if (fc_w1) begin
            cmd_reg.wr <= 1'b1;
            cmd_reg.addr <= req_reg.addr;
            cmd_reg.wdata <= value_in;
            wr_left_reg <= 16'h0001;
            state_reg <= S_WR_WAIT;
          end else if (fc_wm || fc_rw) begin
            state_reg <= S_WR_GET;
          end else begin
            state_reg <= S_HDR;
          end
        end
        S_WR_GET: begin
          if (WORD_VALID_I && word_ready_reg) begin
            word_ready_reg <= 1'b0;
            cmd_reg.wr <= 1'b1;
            cmd_reg.addr <= wr_addr_reg;
            cmd_reg.wdata <= word_in;
            state_reg <= S_WR_WAIT;
          end else begin
            word_ready_reg <= 1'b1;
          end
        end
        S_WR_WAIT: begin
          if (REG_RSP_I.ack) begin
            wr_left_reg <= wr_left_reg - 16'h0001;
            wr_addr_reg <= wr_addr_reg + 16'h0001;
            if (wr_left_reg != 16'h0001) begin
              state_reg <= S_WR_GET;
            end else if (req_reg.broadcast) begin
              state_reg <= S_END;
            end else begin
              state_reg <= S_HDR;
            end
          end
        end
        S_HDR, S_DATA: begin
          if (sending && !rsp_valid_reg) begin
            rsp_valid_reg <= 1'b1;
            rsp_byte_reg <= cur_byte;
            rsp_last_reg <= end_last;
          end else if (take) begin
            rsp_valid_reg <= 1'b0;
            rsp_last_reg <= 1'b0;
            idx_reg <= idx_reg + 3'h1;
            if (state_reg == S_DATA) begin
              dbuf_reg <= {dbuf_reg[23:0], 8'h00};
              if (data_last) begin
                idx_reg <= 3'h0;
                rd_left_reg <= rd_left_reg - dwords;
                rd_addr_reg <= rd_addr_reg + dwords;
                state_reg <= (rd_left_reg == dwords) ? S_END : S_RD_REQ;
              end
            end else if (hdr_last) begin
              idx_reg <= 3'h0;
              state_reg <= has_data ? S_RD_REQ : S_END;
            end
          end
        end
        S_RD_REQ: begin
          cmd_reg.rd <= 1'b1;
          cmd_reg.addr <= rd_addr_reg;
          state_reg <= S_RD_WAIT;
        end
        S_RD_WAIT: begin
          if (REG_RSP_I.ack) begin
            dbuf_reg <= fmt_seq;
            dlen_reg <= load_four ? 3'h4 : 3'h2;
            state_reg <= S_DATA;
          end
        end
        S_END: begin
          // back to sleep after the answer
          awake_reg <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: begin
          state_reg <= S_IDLE;
        end
      endcase
    end
  end

  assign REQ_READY_O = req_ready_reg;
  assign WORD_READY_O = word_ready_reg;
  assign REG_CMD_O = cmd_reg;
  assign XCVR_ON_O = xcvr_reg;
  assign RSP_VALID_O = rsp_valid_reg;
  assign RSP_BYTE_O = rsp_byte_reg;
  assign RSP_LAST_O = rsp_last_reg;

  default clocking cb @(posedge MCLK_I);
  endclocking
  default disable iff (!RESETN_I);

  bcast_silent_a : assert property (rsp_valid_reg |-> !req_reg.broadcast)
    else $error("reply sent for a broadcast");
  resp_delay_a : assert property (state_reg == S_HDR && rsp_valid_reg && idx_reg == 3'h0 |-> delay_done)
    else $error("reply started before turnaround time");
  write_first_a : assert property (cmd_reg.rd |-> wr_left_reg == 16'h0000 || !fc_rw)
    else $error("read issued before writes done");
  wake_drop_a : assert property (CE_I && state_reg == S_DECODE && ps_active && !awake_reg
    |=> state_reg == S_IDLE && awake_reg && !rsp_valid_reg)
    else $error("wake telegram not dropped");
  xcvr_sleep_a : assert property (ps_active && !awake_reg ##1 ps_active && !awake_reg && CE_I |=> !XCVR_ON_O)
    else $error("transceiver on while asleep");
  switch_gate_a : assert property (CE_I && state_reg == S_DECODE && comm_blocked |=> state_reg == S_IDLE)
    else $error("request served with switch off");
  illegal_fc_a : assert property (CE_I && state_reg == S_DECODE && fc_illegal && !comm_blocked && !ps_active
    && !req_reg.broadcast |=> exc_reg && exc_code_reg == EXC_ILLEGAL_FUNC && state_reg == S_HDR)
    else $error("illegal function not flagged");
  read_limit_a : assert property (CE_I && state_reg == S_DECODE && fc_rd && req_reg.count > MAX_READ_REGS
    |=> exc_reg && exc_code_reg == EXC_ILLEGAL_VALUE)
    else $error("read count over limit accepted");
  single_write_a : assert property (CE_I && state_reg == S_DECODE && fc_w1 && !comm_blocked
    && !(ps_active && !awake_reg) |=> cmd_reg.wr && cmd_reg.addr == req_reg.addr && wr_left_reg == 16'h0001)
    else $error("single write misdecoded");
  bcast_only_a : assert property (CE_I && state_reg == S_DECODE && req_reg.broadcast && !bc_allowed
    && !comm_blocked && !(ps_active && !awake_reg) |=> state_reg == S_END ##1 state_reg == S_IDLE)
    else $error("forbidden broadcast executed");

  read_reply_c : cover property (state_reg == S_DATA && take && end_last);
  exc_reply_c : cover property (exc_reg && take && rsp_last_reg);
  bcast_write_c : cover property (req_reg.broadcast && state_reg == S_WR_WAIT && REG_RSP_I.ack);
  wake_c : cover property (state_reg == S_DECODE && ps_active && !awake_reg);
endmodule : mbsfe_engine
`default_nettype wire

// >>> sim/mbsfe_reg_model.sv
`timescale 1ns/10ps
`default_nettype none
module mbsfe_reg_model (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire mbsfe_pkg::mbsfe_reg_cmd_t cmd_i,
  output mbsfe_pkg::mbsfe_reg_rsp_t rsp_o
);
  import mbsfe_pkg::*;
  logic [15:0] mem [256];
  logic [2:0] wait_reg;
  logic busy_reg, wr_reg, slow_reg;
  logic [15:0] addr_reg, wdata_reg;
  logic [7:0] a0, a1;
  assign a0 = addr_reg[7:0];
  assign a1 = addr_reg[7:0] + 8'h01;
  // address bits 13:12 pick int, float or string; ack latency alternates 1 and 4
  always @(posedge clk_i) begin
    rsp_o.ack <= 1'b0;
    // data does not hold once the answer is gone
    rsp_o.rdata <= ~rsp_o.rdata;
    if (!rstn_i) begin
      busy_reg <= 1'b0;
      slow_reg <= 1'b0;
      rsp_o <= '0;
      for (int i = 0; i < 256; i++) mem[i] <= {8'(i) ^ 8'h5A, 8'(i)};
    end else if (cmd_i.rd || cmd_i.wr) begin
      busy_reg <= 1'b1;
      wr_reg <= cmd_i.wr;
      addr_reg <= cmd_i.addr;
      wdata_reg <= cmd_i.wdata;
      wait_reg <= slow_reg ? 3'h4 : 3'h1;
      slow_reg <= ~slow_reg;
    end else if (busy_reg && wait_reg > 3'h1) begin
      wait_reg <= wait_reg - 3'h1;
    end else if (busy_reg) begin
      busy_reg <= 1'b0;
      rsp_o.ack <= 1'b1;
      rsp_o.rtype <= addr_reg[13:12];
      rsp_o.rdata <= (addr_reg[13:12] == TYPE_FLOAT) ? {mem[a0], mem[a1]} : {16'h0000, mem[a0]};
      if (wr_reg) mem[a0] <= wdata_reg;
    end
  end
endmodule : mbsfe_reg_model
`default_nettype wire

// >>> sim/mbsfe_engine_tb.sv
`timescale 1ns/10ps
`default_nettype none
module mbsfe_engine_tb;
  import mbsfe_pkg::*;
  typedef logic [7:0] mbsfe_bq_t[$];
  localparam int DLY = 20;
  logic MCLK_I = 1'b0, RESETN_I = 1'b0, REQ_VALID_I = 1'b0, WORD_VALID_I = 1'b0, BYTE_ORDER_LOAD_I = 1'b0;
  logic MAINS_PRESENT_I = 1'b1, POWER_SAVE_ENABLE_SWITCH_I = 1'b0, RSP_READY_I = 1'b1, CE_I = 1'b1;
  mbsfe_req_t REQ_I = '0;
  logic [15:0] WORD_I = 16'h0000;
  logic [1:0] BYTE_ORDER_I = 2'h0;
  logic REQ_READY_O, WORD_READY_O, XCVR_ON_O, RSP_VALID_O, RSP_LAST_O;
  logic [7:0] RSP_BYTE_O;
  mbsfe_reg_cmd_t REG_CMD_O;
  mbsfe_reg_rsp_t REG_RSP_I;
  int errors = 0;
  int checks_done = 0;
  mbsfe_bq_t rq;
  always #2.5 MCLK_I = ~MCLK_I;
  mbsfe_engine #(.RESP_DELAY_CYC(DLY)) dut (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I), .CE_I(CE_I),
    .REQ_VALID_I(REQ_VALID_I), .REQ_I(REQ_I), .REQ_READY_O(REQ_READY_O), .WORD_VALID_I(WORD_VALID_I),
    .WORD_I(WORD_I), .WORD_READY_O(WORD_READY_O), .REG_CMD_O(REG_CMD_O), .REG_RSP_I(REG_RSP_I),
    .DIAG_REG_I(16'hC3A5), .BYTE_ORDER_LOAD_I(BYTE_ORDER_LOAD_I), .BYTE_ORDER_I(BYTE_ORDER_I),
    .MAINS_PRESENT_I(MAINS_PRESENT_I), .POWER_SAVE_ENABLE_SWITCH_I(POWER_SAVE_ENABLE_SWITCH_I),
    .XCVR_ON_O(XCVR_ON_O), .RSP_VALID_O(RSP_VALID_O), .RSP_BYTE_O(RSP_BYTE_O), .RSP_LAST_O(RSP_LAST_O),
    .RSP_READY_I(RSP_READY_I));
  mbsfe_reg_model partner (.clk_i(MCLK_I), .rstn_i(RESETN_I), .cmd_i(REG_CMD_O), .rsp_o(REG_RSP_I));

  task automatic give_verdict();
    if (errors == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [271:0] seen, input logic [271:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // response length on top, byte i at bits 8*i
  function automatic logic [271:0] pk(input mbsfe_bq_t q);
    logic [271:0] v;
    v = '0;
    v[271:256] = 16'(q.size());
    for (int i = 0; i < q.size() && i < 32; i++) v[8*i +: 8] = q[i];
    return v;
  endfunction : pk

  function automatic mbsfe_req_t mk(input logic bc, input logic [7:0] f, input logic [15:0] s, a, c, wa, wc, v);
    return '{bc, f, s, a, c, wa, wc, v};
  endfunction : mk

  task automatic xact(input mbsfe_req_t r, input int nw, input logic [15:0] w0, input int lim);
    int t;
    int first;
    logic done;
    rq = {};
    t = 0;
    REQ_I <= r;
    REQ_VALID_I <= 1'b1;
    do begin @(posedge MCLK_I); t++; end while (REQ_READY_O !== 1'b1 && t < 500);
    REQ_VALID_I <= 1'b0;
    t = 0;
    for (int i = 0; i < nw; i++) begin
      WORD_I <= w0 + 16'(i);
      WORD_VALID_I <= 1'b1;
      do begin @(posedge MCLK_I); t++; end while (WORD_READY_O !== 1'b1 && t < lim);
    end
    WORD_VALID_I <= 1'b0;
    done = 1'b0;
    first = 0;
    while (t < lim && !done) begin
      // consumer stalls every third cycle
      RSP_READY_I <= (t % 3 != 2);
      @(posedge MCLK_I);
      t++;
      if (RSP_VALID_O === 1'b1 && RSP_READY_I === 1'b1) begin
        if (rq.size() == 0) first = t;
        rq.push_back(RSP_BYTE_O);
        done = (RSP_LAST_O === 1'b1);
      end
    end
    RSP_READY_I <= 1'b1;
    if (rq.size() > 0) chk(272'(first >= DLY), 272'(1));
  endtask : xact

  task automatic set_order(input logic [1:0] o);
    BYTE_ORDER_I <= o;
    BYTE_ORDER_LOAD_I <= 1'b1;
    @(posedge MCLK_I);
    BYTE_ORDER_LOAD_I <= 1'b0;
    @(posedge MCLK_I);
  endtask : set_order

  task automatic t_reads();
    xact(mk(0, FC_READ_HOLD, 0, 16'h0010, 2, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h03, 8'h04, 8'h4A, 8'h10, 8'h4B, 8'h11}));
    xact(mk(0, FC_READ_INPUT, 0, 16'h0010, 2, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h04, 8'h04, 8'h4A, 8'h10, 8'h4B, 8'h11}));
  endtask : t_reads

  // order load while frozen must be lost
  task automatic t_freeze();
    CE_I <= 1'b0;
    set_order(BO_0123);
    CE_I <= 1'b1;
    xact(mk(0, FC_READ_HOLD, 0, 16'h0010, 1, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h03, 8'h02, 8'h4A, 8'h10}));
  endtask : t_freeze

  task automatic t_orders();
    logic [7:0] b [4];
    int seq [4][4];
    mbsfe_bq_t e;
    logic msb;
    b = '{8'h41, 8'h1B, 8'h40, 8'h1A};
    seq = '{'{1, 0, 3, 2}, '{0, 1, 2, 3}, '{2, 3, 0, 1}, '{3, 2, 1, 0}};
    for (int o = 0; o < 4; o++) begin
      set_order(2'(o));
      msb = (o == 0 || o == 3);
      xact(mk(0, FC_READ_HOLD, 0, 16'h1040, 2, 0, 0, 0), 0, 0, 2000);
      e = '{8'h03, 8'h04, b[seq[o][0]], b[seq[o][1]], b[seq[o][2]], b[seq[o][3]]};
      chk(pk(rq), pk(e));
      xact(mk(0, FC_READ_HOLD, 0, 16'h0010, 1, 0, 0, 0), 0, 0, 2000);
      if (msb) e = '{8'h03, 8'h02, 8'h4A, 8'h10};
      else e = '{8'h03, 8'h02, 8'h10, 8'h4A};
      chk(pk(rq), pk(e));
      xact(mk(0, FC_READ_HOLD, 0, 16'h2080, 2, 0, 0, 0), 0, 0, 2000);
      if (msb) e = '{8'h03, 8'h04, 8'hDA, 8'h80, 8'hDB, 8'h81};
      else e = '{8'h03, 8'h04, 8'h80, 8'hDA, 8'h81, 8'hDB};
      chk(pk(rq), pk(e));
    end
    set_order(BO_1032);
  endtask : t_orders

  task automatic t_writes();
    xact(mk(0, FC_WRITE_SINGLE, 0, 16'h0020, 0, 0, 0, 16'hBEEF), 0, 0, 2000);
    chk(pk(rq), pk('{8'h06, 8'h00, 8'h20, 8'hBE, 8'hEF}));
    xact(mk(0, FC_READ_HOLD, 0, 16'h0020, 2, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h03, 8'h04, 8'hBE, 8'hEF, 8'h7B, 8'h21}));
    xact(mk(0, FC_WRITE_MULTI, 0, 0, 0, 16'h0021, 2, 0), 2, 16'h1234, 2000);
    chk(pk(rq), pk('{8'h10, 8'h00, 8'h21, 8'h00, 8'h02}));
    xact(mk(0, FC_READ_HOLD, 0, 16'h0021, 2, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h03, 8'h04, 8'h12, 8'h34, 8'h12, 8'h35}));
    xact(mk(0, FC_READ_WRITE, 0, 16'h0024, 1, 16'h0024, 1, 0), 1, 16'h7777, 2000);
    chk(pk(rq), pk('{8'h17, 8'h02, 8'h77, 8'h77}));
  endtask : t_writes

  task automatic t_diag();
    xact(mk(0, FC_DIAG, DIAG_SUB_LOOPBACK, 0, 0, 0, 0, 16'h55AA), 0, 0, 2000);
    chk(pk(rq), pk('{8'h08, 8'h00, 8'h00, 8'h55, 8'hAA}));
    xact(mk(0, FC_DIAG, DIAG_SUB_REGISTER, 0, 0, 0, 0, 16'h55AA), 0, 0, 2000);
    chk(pk(rq), pk('{8'h08, 8'h00, 8'h02, 8'hC3, 8'hA5}));
    xact(mk(0, 8'h05, 0, 0, 1, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h85, 8'h01}));
  endtask : t_diag

  task automatic t_bcast();
    xact(mk(1, FC_READ_HOLD, 0, 16'h0030, 1, 0, 0, 0), 0, 0, 300);
    chk(272'(rq.size()), 272'(0));
    xact(mk(1, FC_WRITE_SINGLE, 0, 16'h0030, 0, 0, 0, 16'h4321), 0, 0, 300);
    chk(272'(rq.size()), 272'(0));
    xact(mk(1, FC_WRITE_MULTI, 0, 0, 0, 16'h0031, 1, 0), 1, 16'h9999, 300);
    chk(272'(rq.size()), 272'(0));
    xact(mk(0, FC_READ_HOLD, 0, 16'h0030, 2, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h03, 8'h04, 8'h43, 8'h21, 8'h99, 8'h99}));
  endtask : t_bcast

  task automatic t_limits();
    xact(mk(0, FC_READ_HOLD, 0, 16'h0000, 16'd125, 0, 0, 0), 0, 0, 6000);
    chk(272'({16'(rq.size()), rq[0], rq[1]}), 272'({16'd252, 8'h03, 8'hFA}));
    xact(mk(0, FC_READ_INPUT, 0, 16'h0000, 16'd126, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h84, 8'h03}));
    xact(mk(0, FC_WRITE_MULTI, 0, 0, 0, 16'h0000, 16'd121, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h90, 8'h03}));
    xact(mk(0, FC_WRITE_MULTI, 0, 0, 0, 16'h0000, 16'd120, 0), 120, 16'h0100, 6000);
    chk(pk(rq), pk('{8'h10, 8'h00, 8'h00, 8'h00, 8'h78}));
    xact(mk(0, FC_READ_WRITE, 0, 16'h0000, 16'd119, 16'h0000, 1, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h97, 8'h03}));
  endtask : t_limits

  task automatic t_psave();
    MAINS_PRESENT_I <= 1'b0;
    POWER_SAVE_ENABLE_SWITCH_I <= 1'b1;
    repeat (10) @(posedge MCLK_I);
    chk(272'(XCVR_ON_O), 272'(0));
    xact(mk(0, FC_READ_HOLD, 0, 16'h00F0, 1, 0, 0, 0), 0, 0, 300);
    chk(272'(rq.size()), 272'(0));
    chk(272'(XCVR_ON_O), 272'(1));
    // identical retry after no reply
    xact(mk(0, FC_READ_HOLD, 0, 16'h00F0, 1, 0, 0, 0), 0, 0, 2000);
    chk(pk(rq), pk('{8'h03, 8'h02, 8'hAA, 8'hF0}));
    repeat (10) @(posedge MCLK_I);
    chk(272'(XCVR_ON_O), 272'(0));
    POWER_SAVE_ENABLE_SWITCH_I <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      xact(mk(0, FC_READ_HOLD, 0, 16'h00F0, 1, 0, 0, 0), 0, 0, 300);
      chk(272'(rq.size()), 272'(0));
    end
  endtask : t_psave

  initial begin
    repeat (60000) @(posedge MCLK_I);
    errors++;
    give_verdict();
  end

  initial begin
    repeat (8) @(posedge MCLK_I);
    RESETN_I <= 1'b1;
    t_reads();
    t_freeze();
    t_orders();
    t_writes();
    t_diag();
    t_bcast();
    t_limits();
    t_psave();
    give_verdict();
  end
endmodule : mbsfe_engine_tb
`default_nettype wire
